// ===== tb/fault_status_checker.sv
// Concurrent checks on the ports of the fault status register bank
`timescale 1ns/100ps
module fault_status_checker
    import fault_status_pkg::*;
(
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic s_axi_awvalid, // AW valid
    input wire logic s_axi_awready, // AW ready
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_wready, // W ready
    input wire logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic s_axi_arvalid, // AR valid
    input wire logic s_axi_arready, // AR ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic s_axi_rvalid, // R valid
    input wire logic s_axi_rready, // R ready
    input wire fault_inputs_t fault_in, // Detector levels
    input wire logic fault_irq // Interrupt pin state
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wtake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_hot;
        fault_in.thermal_shutdown [*5];
    endsequence
    property p_wr_time;
        s_wtake |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_time: assert property (p_wr_time) else $error("write response late");
    property p_rd_time;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_time: assert property (p_rd_time) else $error("read data late");
    property p_bvalid_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped");
    property p_rvalid_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("read answer not held");
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken during response");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken during answer");
    property p_upper_zero;
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read half not zero");
    property p_irq_rise;
        s_hot |-> fault_irq;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("pin missed thermal fault");
    property p_irq_sticky;
        fault_irq && !s_axi_wvalid && !$past(s_axi_wvalid) && !$past(s_axi_wvalid, 2) |=> fault_irq;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("pin fell without clear");
endmodule

bind backlight_fault_status_regs fault_status_checker fault_status_checker_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fault_in(fault_in), .fault_irq(fault_irq));

// ===== tb/test_backlight_fault_status_regs.sv
// Register-level testbench of the fault status register bank
`timescale 1ns/100ps
`include "fault_status_defines.svh"
module test_backlight_fault_status_regs
    import fault_status_pkg::*;
;
    localparam logic [11:0] boost_a = `BOOST_REG_ADDR;
    localparam logic [11:0] led_a = `LED_REG_ADDR;
    localparam logic [11:0] ien_a = `IRQ_ENABLE_ADDR;
    localparam logic [1:0] ok = `AXI_RESP_OKAY;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, fault_irq;
    logic [1:0] bresp, rresp;
    fault_inputs_t fault_in = '0;
    logic [15:0] led_set [5] = '{16'h4000, 16'h1000, 16'h0500, 16'h0480, 16'h0440};
    logic [15:0] led_clr [5] = '{16'h6000, 16'h1800, 16'h0600, 16'h0600, 16'h0600};
    int err_total = 0, cmp_count = 0;
    always #20 aclk = ~aclk;
    backlight_fault_status_regs backlight_fault_status_regs_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .fault_in(fault_in), .fault_irq(fault_irq));
    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %b, seen %b", n, e, g);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge aclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 50);
        bready <= 1'b0;
        chk_bit("bvalid", 1'b1, bvalid);
        chk_resp("bresp", er, bresp);
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 50);
        rready <= 1'b0;
        chk_word("rdata", {16'h0000, e}, rdata);
        chk_resp("rresp", er, rresp);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(40 * 5000);
        err_total++;
        wrap_up();
    end
    initial begin
        tick(4);
        aresetn <= 1'b1;
        rd(boost_a, 16'h0000, ok);
        rd(led_a, 16'h0000, ok);
        rd(ien_a, 16'h002a, ok);
        chk_bit("fault_irq", 1'b0, fault_irq);
        $display("test reset_values done");
        for (int k = 0; k < 8; k++) begin
            fault_in <= fault_inputs_t'(17'h00200 << k);
            tick(6);
            fault_in <= '0;
            rd(boost_a, 16'h0002 << (2 * k), ok);
            chk_bit("fault_irq", k != 0, fault_irq);
            wr(boost_a, 16'h0002 << (2 * k), ok);
            wr(boost_a, 16'h0001 << (2 * k), ok);
            rd(boost_a, 16'h0002 << (2 * k), ok);
            wr(boost_a, 16'h0003 << (2 * k), ok);
            rd(boost_a, 16'h0000, ok);
            chk_bit("fault_irq", 1'b0, fault_irq);
        end
        $display("test boost_pairs done");
        for (int j = 0; j < 5; j++) begin
            fault_in <= fault_inputs_t'(17'h00100 >> j);
            tick(6);
            fault_in <= '0;
            rd(led_a, led_set[j], ok);
            chk_bit("fault_irq", 1'b1, fault_irq);
            wr(led_a, led_set[j], ok);
            rd(led_a, led_set[j], ok);
            wr(led_a, led_clr[j], ok);
            rd(led_a, 16'h0000, ok);
            chk_bit("fault_irq", 1'b0, fault_irq);
        end
        $display("test led_pairs done");
        wr(ien_a, 16'h0015, ok);
        rd(ien_a, 16'h0000, ok);
        fault_in <= fault_inputs_t'(17'h00100);
        tick(6);
        fault_in <= '0;
        chk_bit("fault_irq", 1'b0, fault_irq);
        wr(led_a, 16'h6000, ok);
        wr(ien_a, 16'h003f, ok);
        rd(ien_a, 16'h002a, ok);
        $display("test irq_enable done");
        fault_in <= fault_inputs_t'(17'h0000a);
        tick(4);
        wr(led_a, 16'h8005, ok);
        rd(led_a, 16'h000a, ok);
        fault_in <= '0;
        tick(4);
        rd(led_a, 16'h0000, ok);
        wr(12'h100, 16'hffff, `AXI_RESP_SLVERR);
        rd(12'h100, 16'h0000, `AXI_RESP_SLVERR);
        $display("test channels_unmapped done");
        wrap_up();
    end
endmodule

// ===== verilog/backlight_fault_status_regs.sv
// AXI4-Lite fault status register bank of an LED backlight driver
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "fault_status_defines.svh"

// How it works
// - boost bit 15 thermal shutdown flag, cleared with bit 14.
// - boost bit 13 current resistor short flag, cleared with bit 12.
// - boost bit 11 string resistor missing flag, cleared with bit 10.
// - boost bit 9 mode resistor missing flag, cleared with bit 8.
// - boost bit 7 frequency resistor missing flag, cleared with bit 6.
// - boost bit 5 boost over-current flag, cleared with bit 4.
// - boost bit 3 over-voltage high flag, cleared with bit 2.
// - boost bit 1 over-voltage low flag, cleared with bit 0; no pin effect.
// - writing ones to flag and clear together clears flag and pin state.
// - LED bit 15 is reserved and reads zero.
// - LED bit 14 serial time-out flag, cleared with bit 13.
// - LED bit 12 bad string configuration flag, cleared with bit 11.
// - LED bit 10 summary of open or short faults, cleared with bit 9.
// - LED bit 8 ground short flag, cleared with the summary.
// - LED bit 7 internal short flag, cleared with the summary.
// - LED bit 6 open flag, cleared with the summary.
// - LED bits 3 to 0 read-only channel 4 to 1 fault flags.
// - boost status register resets to zero.
// - enable fields: write 3 enables, 1 disables; read 2 or 0.
module backlight_fault_status_regs
    import fault_status_pkg::*;
(
    input wire logic aclk, // Bus clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire fault_inputs_t fault_in, // Detector levels from analog side
    output logic fault_irq // Interrupt pin state, active high
);

    fault_inputs_t sync1_q;
    fault_inputs_t sync2_q;
    logic [7:0] boost_flag_q; // thermal on top, low over-voltage at 0
    logic [2:0] led_flag_q; // timeout, config, summary
    logic ground_q;
    logic intshort_q;
    logic open_q;
    logic [3:0] chan_q;
    logic [2:0] irq_en_q; // timeout, config, summary
    logic aw_hold_q;
    logic w_hold_q;
    logic [11:0] awaddr_q;
    logic [15:0] wdata_q;
    logic [1:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic do_write;
    logic ar_take;
    logic [15:0] wr16;
    logic [1:0] wr_lanes;
    logic boost_hit;
    logic led_hit;
    logic ien_hit;
    logic wr_mapped;
    logic [7:0] boost_set;
    logic [2:0] led_set;
    logic [7:0] boost_clr;
    logic [2:0] led_clr;
    logic irq_boost;
    logic irq_led;
    logic [15:0] boost_word;
    logic [15:0] led_word;

    // Register select by word index
    function automatic logic word_sel(input logic [11:0] addr, input logic [7:0] index);
        return addr[11:2] == {2'b00, index};
    endfunction

    // Both ones in a flag/clear pair within enabled lanes
    function automatic logic pair_clear(input logic [15:0] d, input logic [1:0] lanes, input int fb, input int cb);
        logic ok;
        ok = lanes[fb / 8] && lanes[cb / 8];
        return ok && d[fb] && d[cb];
    endfunction

    // Two-bit enable field update
    function automatic logic ien_next(input logic cur, input logic [1:0] code);
        logic n;
        n = cur;
        if (code == `IEN_WR_ENABLE) begin
            n = 1'b1;
        end else if (code == `IEN_WR_DISABLE) begin
            n = 1'b0;
        end
        return n;
    endfunction

    // Two-bit enable field read code
    function automatic logic [1:0] ien_rd(input logic en);
        logic [1:0] code;
        code = `IEN_RD_DISABLED;
        if (en) begin
            code = `IEN_RD_ENABLED;
        end
        return code;
    endfunction

    // Detector levels cross in from the analog side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= fault_in;
            sync2_q <= sync1_q;
        end
    end

    // Write address capture, either order with data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_hold_q <= 1'b0;
        end
    end

    // Write data capture, only the low half is mapped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata[15:0];
            wstrb_q <= s_axi_wstrb[1:0];
        end else if (do_write) begin
            w_hold_q <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr16 = wdata_q;
    assign wr_lanes = wstrb_q;
    assign boost_hit = do_write && word_sel(awaddr_q, `BOOST_REG_INDEX);
    assign led_hit = do_write && word_sel(awaddr_q, `LED_REG_INDEX);
    assign ien_hit = do_write && word_sel(awaddr_q, `IRQ_ENABLE_INDEX);
    assign wr_mapped = boost_hit || led_hit || ien_hit;

    always_comb begin
        // needs both bits of the pair
        boost_clr[7] = boost_hit && pair_clear(wr16, wr_lanes, `BOOST_THERMAL_BIT, `BOOST_THERMAL_CLR);
        boost_clr[6] = boost_hit && pair_clear(wr16, wr_lanes, `BOOST_CURSHORT_BIT, `BOOST_CURSHORT_CLR);
        boost_clr[5] = boost_hit && pair_clear(wr16, wr_lanes, `BOOST_STRRES_BIT, `BOOST_STRRES_CLR);
        boost_clr[4] = boost_hit && pair_clear(wr16, wr_lanes, `BOOST_MODERES_BIT, `BOOST_MODERES_CLR);
        boost_clr[3] = boost_hit && pair_clear(wr16, wr_lanes, `BOOST_FREQRES_BIT, `BOOST_FREQRES_CLR);
        boost_clr[2] = boost_hit && pair_clear(wr16, wr_lanes, `BOOST_OVERCUR_BIT, `BOOST_OVERCUR_CLR);
        boost_clr[1] = boost_hit && pair_clear(wr16, wr_lanes, `BOOST_OVHIGH_BIT, `BOOST_OVHIGH_CLR);
        boost_clr[0] = boost_hit && pair_clear(wr16, wr_lanes, `BOOST_OVLOW_BIT, `BOOST_OVLOW_CLR);
        led_clr[2] = led_hit && pair_clear(wr16, wr_lanes, `LED_TIMEOUT_BIT, `LED_TIMEOUT_CLR);
        led_clr[1] = led_hit && pair_clear(wr16, wr_lanes, `LED_CONFIG_BIT, `LED_CONFIG_CLR);
        led_clr[0] = led_hit && pair_clear(wr16, wr_lanes, `LED_SUMMARY_BIT, `LED_SUMMARY_CLR);
    end

    // Detector levels in flag order
    always_comb begin
        boost_set[7] = sync2_q.thermal_shutdown;
        boost_set[6] = sync2_q.current_resistor_short;
        boost_set[5] = sync2_q.string_resistor_missing;
        boost_set[4] = sync2_q.mode_resistor_missing;
        boost_set[3] = sync2_q.freq_resistor_missing;
        boost_set[2] = sync2_q.boost_overcurrent;
        boost_set[1] = sync2_q.boost_overvoltage_high;
        boost_set[0] = sync2_q.boost_overvoltage_low;
        led_set[2] = sync2_q.serial_timeout;
        led_set[1] = sync2_q.bad_string_config;
        led_set[0] = sync2_q.string_ground_short || sync2_q.string_internal_short || sync2_q.string_open;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boost_flag_q <= '0;
        end else begin
            boost_flag_q <= (boost_flag_q & ~boost_clr) | boost_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_flag_q <= '0;
        end else begin
            led_flag_q <= (led_flag_q & ~led_clr) | led_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ground_q <= 1'b0;
        end else begin
            ground_q <= (ground_q && !led_clr[0]) || sync2_q.string_ground_short;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            intshort_q <= 1'b0;
        end else begin
            intshort_q <= (intshort_q && !led_clr[0]) || sync2_q.string_internal_short;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            open_q <= 1'b0;
        end else begin
            open_q <= (open_q && !led_clr[0]) || sync2_q.string_open;
        end
    end

    // channel flags follow the channel detectors
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_q <= '0;
        end else begin
            chan_q <= sync2_q.channel_fault;
        end
    end

    // enable fields: summary 1:0, config 3:2, timeout 5:4
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_q <= `IRQ_ENABLE_RESET;
        end else if (ien_hit && wstrb_q[0]) begin
            irq_en_q[0] <= ien_next(irq_en_q[0], wr16[1:0]);
            irq_en_q[1] <= ien_next(irq_en_q[1], wr16[3:2]);
            irq_en_q[2] <= ien_next(irq_en_q[2], wr16[5:4]);
        end
    end

    // Pin sources
    always_comb begin
        irq_boost = |boost_flag_q[7:1];
        irq_led = (led_flag_q[2] && irq_en_q[2]) || (led_flag_q[1] && irq_en_q[1]) ||
            (led_flag_q[0] && irq_en_q[0]);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_irq <= 1'b0;
        end else begin
            fault_irq <= irq_boost || irq_led;
        end
    end

    // reserved bits read zero; clear bits read zero
    always_comb begin
        boost_word = '0;
        boost_word[`BOOST_THERMAL_BIT] = boost_flag_q[7];
        boost_word[`BOOST_CURSHORT_BIT] = boost_flag_q[6];
        boost_word[`BOOST_STRRES_BIT] = boost_flag_q[5];
        boost_word[`BOOST_MODERES_BIT] = boost_flag_q[4];
        boost_word[`BOOST_FREQRES_BIT] = boost_flag_q[3];
        boost_word[`BOOST_OVERCUR_BIT] = boost_flag_q[2];
        boost_word[`BOOST_OVHIGH_BIT] = boost_flag_q[1];
        boost_word[`BOOST_OVLOW_BIT] = boost_flag_q[0];
        led_word = '0;
        led_word[`LED_TIMEOUT_BIT] = led_flag_q[2];
        led_word[`LED_CONFIG_BIT] = led_flag_q[1];
        led_word[`LED_SUMMARY_BIT] = led_flag_q[0];
        led_word[`LED_GROUND_BIT] = ground_q;
        led_word[`LED_INTSHORT_BIT] = intshort_q;
        led_word[`LED_OPEN_BIT] = open_q;
        led_word[3:0] = chan_q;
    end

    // Write response valid, held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Write response code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp_q <= `AXI_RESP_OKAY;
        end else if (do_write) begin
            bresp_q <= wr_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end
    end

    assign ar_take = s_axi_arvalid && s_axi_arready;

    // Read valid, one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Read data and code, captured with the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_q <= '0;
            rresp_q <= `AXI_RESP_OKAY;
        end else if (ar_take) begin
            rresp_q <= `AXI_RESP_OKAY;
            if (word_sel(s_axi_araddr, `BOOST_REG_INDEX)) begin
                rdata_q <= {16'h0000, boost_word};
            end else if (word_sel(s_axi_araddr, `LED_REG_INDEX)) begin
                rdata_q <= {16'h0000, led_word};
            end else if (word_sel(s_axi_araddr, `IRQ_ENABLE_INDEX)) begin
                rdata_q <= {26'h0000000, ien_rd(irq_en_q[2]), ien_rd(irq_en_q[1]), ien_rd(irq_en_q[0])};
            end else begin
                rdata_q <= '0;
                rresp_q <= `AXI_RESP_SLVERR;
            end
        end
    end

    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule

// ===== verilog/fault_status_defines.svh
// Offsets, field positions and reset values of the fault status registers
`ifndef FAULT_STATUS_DEFINES_SVH
`define FAULT_STATUS_DEFINES_SVH

// Printed offsets are not all multiples of four: they are word indexes
`define BOOST_REG_INDEX 8'h10
`define LED_REG_INDEX 8'h12
`define IRQ_ENABLE_INDEX 8'h13
`define BOOST_REG_ADDR 12'h040
`define LED_REG_ADDR 12'h048
`define IRQ_ENABLE_ADDR 12'h04c
`define BOOST_REG_RESET 16'h0000
`define LED_REG_RESET 16'h0000
`define IRQ_ENABLE_RESET 3'h7

// Boost flag and clear bit pairs
`define BOOST_THERMAL_BIT 15
`define BOOST_THERMAL_CLR 14
`define BOOST_CURSHORT_BIT 13
`define BOOST_CURSHORT_CLR 12
`define BOOST_STRRES_BIT 11
`define BOOST_STRRES_CLR 10
`define BOOST_MODERES_BIT 9
`define BOOST_MODERES_CLR 8
`define BOOST_FREQRES_BIT 7
`define BOOST_FREQRES_CLR 6
`define BOOST_OVERCUR_BIT 5
`define BOOST_OVERCUR_CLR 4
`define BOOST_OVHIGH_BIT 3
`define BOOST_OVHIGH_CLR 2
`define BOOST_OVLOW_BIT 1
`define BOOST_OVLOW_CLR 0
// LED pairs: time-out 14/13, string config 12/11, summary 10/9
`define LED_TIMEOUT_BIT 14
`define LED_TIMEOUT_CLR 13
`define LED_CONFIG_BIT 12
`define LED_CONFIG_CLR 11
`define LED_SUMMARY_BIT 10
`define LED_SUMMARY_CLR 9
`define LED_GROUND_BIT 8
`define LED_INTSHORT_BIT 7
`define LED_OPEN_BIT 6

// Interrupt enable field codes
`define IEN_WR_ENABLE 2'h3
`define IEN_WR_DISABLE 2'h1
`define IEN_RD_ENABLED 2'h2
`define IEN_RD_DISABLED 2'h0

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ===== verilog/fault_status_pkg.sv
// Types shared by the fault status register bank
package fault_status_pkg;

    // Detector inputs, one level per fault source
    typedef struct packed {
        logic thermal_shutdown;
        logic current_resistor_short;
        logic string_resistor_missing;
        logic mode_resistor_missing;
        logic freq_resistor_missing;
        logic boost_overcurrent;
        logic boost_overvoltage_high;
        logic boost_overvoltage_low;
        logic serial_timeout;
        logic bad_string_config;
        logic string_ground_short;
        logic string_internal_short;
        logic string_open;
        logic [3:0] channel_fault;
    } fault_inputs_t;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_RESP
    } read_state_t;

endpackage
